// ===== verilog/uart_tx_pkg.sv
// constants for the asynchronous serial transmit channel
// shared by the channel top and its bit timer; no other dependencies
package uart_tx_pkg;

  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 16;

  // register byte addresses
  localparam logic [5:0] MODE_OFS     = 6'h00;
  localparam logic [5:0] FORMAT_OFS   = 6'h04;
  localparam logic [5:0] DATA_OFS     = 6'h08;
  localparam logic [5:0] INVERT_OFS   = 6'h0C;
  localparam logic [5:0] VALUE_OFS    = 6'h10;
  localparam logic [5:0] ENABLE_OFS   = 6'h14;
  localparam logic [5:0] START_OFS    = 6'h18;
  localparam logic [5:0] STOP_OFS     = 6'h1C;
  localparam logic [5:0] STATUS_OFS   = 6'h20;

  // reset values
  localparam logic [15:0] MODE_RST    = 16'h0020;
  localparam logic [15:0] FORMAT_RST  = 16'h0017;
  localparam logic [15:0] DATA_RST    = 16'h0000;
  localparam logic [15:0] INVERT_RST  = 16'h0000;
  localparam logic [15:0] VALUE_RST   = 16'h0F0F;
  localparam logic [15:0] ENABLE_RST  = 16'h0000;

  // mode register fields
  localparam int unsigned IRQ_SRC_BIT   = 0;
  localparam int unsigned OP_MODE_LSB   = 1;
  localparam int unsigned CLK_SRC_BIT   = 14;
  localparam int unsigned OP_CLK_BIT    = 15;

  // format register fields
  localparam int unsigned LEN_LSB       = 0;
  localparam int unsigned STOP_LSB      = 4;
  localparam int unsigned ORDER_BIT     = 7;
  localparam int unsigned PARITY_LSB    = 8;

  // data register fields
  localparam int unsigned PAYLOAD_W     = 9;
  localparam int unsigned DIV_LSB       = 9;
  localparam int unsigned DIV_W         = 7;
  localparam logic [6:0]  DIV_MIN       = 7'h02;

  // status register bits
  localparam int unsigned STAT_EN_BIT   = 0;
  localparam int unsigned STAT_BUSY_BIT = 1;
  localparam int unsigned STAT_FULL_BIT = 2;

  // codes
  localparam logic [1:0] LEN_9      = 2'h1;
  localparam logic [1:0] LEN_7      = 2'h2;
  localparam logic [1:0] PAR_NONE   = 2'h0;
  localparam logic [1:0] PAR_ZERO   = 2'h1;
  localparam logic [1:0] PAR_EVEN   = 2'h2;
  localparam logic [1:0] STOP_TWO   = 2'h2;
  localparam logic [3:0] BITS_7     = 4'h7;
  localparam logic [3:0] BITS_8     = 4'h8;
  localparam logic [3:0] BITS_9     = 4'h9;

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP
  } frame_state_t;

endpackage : uart_tx_pkg

// ===== verilog/baud_bit_timer.sv
// bit period timer: counts channel operation ticks into transfer ticks
// assumes op_tick is a one-cycle enable pulse from the unit prescaler
`timescale 1ns/100ps
module baud_bit_timer (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_b,
  input  wire logic                    run,
  input  wire logic                    op_tick,
  input  wire logic [uart_tx_pkg::DIV_W-1:0] divider,
  output logic                         bit_tick_reg
);
  import uart_tx_pkg::*;

  logic [7:0] count_reg;
  logic [7:0] last_count;

  // one bit lasts 2*(divider+1) operation ticks; divider clamped at minimum
  always_comb begin
    last_count = {(divider < DIV_MIN) ? DIV_MIN : divider, 1'b1};
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_reg    <= 8'h00;
      bit_tick_reg <= 1'b0;
    end else if (!run) begin
      count_reg    <= 8'h00;
      bit_tick_reg <= 1'b0;
    end else if (op_tick) begin
      bit_tick_reg <= (count_reg == last_count);
      count_reg    <= (count_reg == last_count) ? 8'h00 : count_reg + 8'h01;
    end else begin
      bit_tick_reg <= 1'b0;
    end
  end

endmodule : baud_bit_timer

// ===== verilog/uart_tx_channel.sv
// transmit channel of an asynchronous serial array unit
// assumes prescaler ticks come from logic on sys_clk (no synchroniser)
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/100ps
module uart_tx_channel #(
  parameter int unsigned CHANNEL = 0,
  parameter bit          NINE_BIT_OK = 1'b1
) (
  input  wire logic                          sys_clk,
  input  wire logic                          rst_b,
  input  wire logic [uart_tx_pkg::ADDR_W-1:0] addr,
  input  wire logic [uart_tx_pkg::DATA_W-1:0] wdata,
  input  wire logic                          wr_stb,
  input  wire logic                          rd_stb,
  output logic      [uart_tx_pkg::DATA_W-1:0] rdata_reg,
  input  wire logic                          prescaler_clock_a,
  input  wire logic                          prescaler_clock_b,
  output logic                               txd_reg,
  output logic                               txd_oe_reg,
  output logic                               tx_irq_reg
);
  import uart_tx_pkg::*;

  // only eight channel bits fit below the clock output bits
  if (CHANNEL > 7) begin : g_bad_channel
    $error("CHANNEL must be 0 to 7");
  end

  logic [15:0]  channel_mode_reg;
  logic [15:0]  channel_format_reg;
  logic [15:0]  channel_data_baud_reg;
  logic [15:0]  unit_output_invert_reg;
  logic [15:0]  unit_output_value_reg;
  logic [15:0]  unit_output_enable_reg;
  logic         channel_enabled_reg;
  logic         pending_reg;
  logic [8:0]   shift_reg;
  logic [3:0]   index_reg;
  frame_state_t state_reg;
  logic         op_tick;
  logic         bit_tick;
  logic         load;
  logic         frame_end;
  logic         frame_bit;
  logic         inv;
  logic [3:0]   data_len;
  logic [3:0]   stop_len;
  logic [1:0]   parity_mode;

  function automatic logic wr_hit(input logic [5:0] ofs);
    wr_hit = wr_stb && (addr == ofs);
  endfunction : wr_hit

  function automatic logic [3:0] len_of(input logic [1:0] code);
    unique case (code)
      LEN_9:   len_of = NINE_BIT_OK ? BITS_9 : BITS_8;
      LEN_7:   len_of = BITS_7;
      default: len_of = BITS_8;
    endcase
  endfunction : len_of

  function automatic logic [8:0] mask_of(input logic [3:0] len);
    mask_of = 9'h1FF >> (4'h9 - len);
  endfunction : mask_of

  assign inv         = unit_output_invert_reg[CHANNEL];
  assign data_len    = len_of(channel_format_reg[LEN_LSB +: 2]);
  assign stop_len    = (channel_format_reg[STOP_LSB +: 2] == STOP_TWO) ?
                       4'h2 : 4'h1;
  assign parity_mode = channel_format_reg[PARITY_LSB +: 2];
  // operation clock from the selected prescaler output
  assign op_tick     = channel_mode_reg[OP_CLK_BIT] ?
                       prescaler_clock_b : prescaler_clock_a;
  assign load        = (state_reg == ST_IDLE) && pending_reg &&
                       channel_enabled_reg;
  assign frame_end   = (state_reg == ST_STOP) && bit_tick &&
                       (index_reg == stop_len - 4'h1);

  // transfer clock source bit 14 has only the divided setting
  baud_bit_timer u_timer (
    .sys_clk      (sys_clk),
    .rst_b        (rst_b),
    // timer runs from the load, so the start bit gets a full period
    .run          (state_reg != ST_IDLE || load),
    .op_tick      (op_tick),
    .divider      (channel_data_baud_reg[DIV_LSB +: DIV_W]),
    .bit_tick_reg (bit_tick)
  );

  // unencoded bit for the current frame position
  always_comb begin
    unique case (state_reg)
      ST_START:  frame_bit = 1'b0;
      ST_DATA:   frame_bit = channel_format_reg[ORDER_BIT] ?
                   shift_reg[index_reg] :
                   shift_reg[data_len - 4'h1 - index_reg];
      ST_PARITY: begin
        unique case (parity_mode)
          PAR_ZERO: frame_bit = 1'b0;
          PAR_EVEN: frame_bit = ^shift_reg;
          default:  frame_bit = ~^shift_reg;
        endcase
      end
      default:   frame_bit = 1'b1;
    endcase
  end

  // software registers; mode and format held as written
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      channel_mode_reg       <= MODE_RST;
      channel_format_reg     <= FORMAT_RST;
      channel_data_baud_reg  <= DATA_RST;
      unit_output_invert_reg <= INVERT_RST;
      unit_output_enable_reg <= ENABLE_RST;
    end else begin
      if (wr_hit(MODE_OFS)) begin
        channel_mode_reg <= wdata;
      end
      if (wr_hit(FORMAT_OFS)) begin
        channel_format_reg <= wdata;
      end
      if (wr_hit(DATA_OFS)) begin
        channel_data_baud_reg <= wdata;
      end
      if (wr_hit(INVERT_OFS)) begin
        unit_output_invert_reg <= wdata;
      end
      if (wr_hit(ENABLE_OFS)) begin
        unit_output_enable_reg <= wdata;
      end
    end
  end

  // channel enable: stop trigger wins over start in the same write
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      channel_enabled_reg <= 1'b0;
    end else if (wr_hit(STOP_OFS) && wdata[CHANNEL]) begin
      channel_enabled_reg <= 1'b0;
    end else if (wr_hit(START_OFS) && wdata[CHANNEL]) begin
      channel_enabled_reg <= 1'b1;
    end
  end

  // buffer full flag; a new write in the load cycle keeps it set
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pending_reg <= 1'b0;
    end else if (wr_hit(DATA_OFS) && channel_enabled_reg) begin
      pending_reg <= 1'b1;
    end else if (load || !channel_enabled_reg) begin
      pending_reg <= 1'b0;
    end
  end

  // frame sequencer
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      index_reg <= 4'h0;
      shift_reg <= 9'h000;
    end else if (!channel_enabled_reg) begin
      state_reg <= ST_IDLE;
      index_reg <= 4'h0;
    end else if (load) begin
      shift_reg <= channel_data_baud_reg[PAYLOAD_W-1:0] & mask_of(data_len);
      state_reg <= ST_START;
      index_reg <= 4'h0;
    end else if (bit_tick) begin
      unique case (state_reg)
        ST_START: begin
          state_reg <= ST_DATA;
          index_reg <= 4'h0;
        end
        ST_DATA: begin
          if (index_reg == data_len - 4'h1) begin
            state_reg <= (parity_mode == PAR_NONE) ? ST_STOP : ST_PARITY;
            index_reg <= 4'h0;
          end else begin
            index_reg <= index_reg + 4'h1;
          end
        end
        ST_PARITY: begin
          state_reg <= ST_STOP;
          index_reg <= 4'h0;
        end
        ST_STOP: begin
          if (frame_end) begin
            state_reg <= ST_IDLE;
          end else begin
            index_reg <= index_reg + 4'h1;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // output value: software writes only while idle; while framing, hardware drives the channel bit and writes are dropped
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      unit_output_value_reg <= VALUE_RST;
    end else if (state_reg != ST_IDLE) begin
      unit_output_value_reg[CHANNEL] <= frame_bit ^ inv;
    end else if (wr_hit(VALUE_OFS)) begin
      unit_output_value_reg <= wdata;
    end
  end

  // pin drive straight from the held value and enable bits
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      txd_reg    <= 1'b1;
      txd_oe_reg <= 1'b0;
    end else begin
      txd_reg    <= unit_output_value_reg[CHANNEL];
      txd_oe_reg <= unit_output_enable_reg[CHANNEL];
    end
  end

  // transmit interrupt pulse, source chosen by mode bit 0
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_irq_reg <= 1'b0;
    end else begin
      tx_irq_reg <= channel_mode_reg[IRQ_SRC_BIT] ? load : frame_end;
    end
  end

  // read port; unmapped addresses return zero
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= 16'h0000;
    end else if (rd_stb) begin
      unique case (addr)
        MODE_OFS:   rdata_reg <= channel_mode_reg;
        FORMAT_OFS: rdata_reg <= channel_format_reg;
        DATA_OFS:   rdata_reg <= channel_data_baud_reg;
        INVERT_OFS: rdata_reg <= unit_output_invert_reg;
        VALUE_OFS:  rdata_reg <= unit_output_value_reg;
        ENABLE_OFS: rdata_reg <= unit_output_enable_reg;
        STATUS_OFS: begin
          rdata_reg <= 16'h0000;
          rdata_reg[STAT_EN_BIT]   <= channel_enabled_reg;
          rdata_reg[STAT_BUSY_BIT] <= state_reg != ST_IDLE;
          rdata_reg[STAT_FULL_BIT] <= pending_reg;
        end
        default:    rdata_reg <= 16'h0000;
      endcase
    end
  end

  a_start_level: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (state_reg == ST_START && $past(state_reg) == ST_START)
      |-> unit_output_value_reg[CHANNEL] == inv)
    else $error("start bit level wrong");

  a_stop_level: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (state_reg == ST_STOP && $past(state_reg) == ST_STOP)
      |-> unit_output_value_reg[CHANNEL] == !inv)
    else $error("stop bit level wrong");

  a_zero_parity: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (state_reg == ST_PARITY && $past(state_reg) == ST_PARITY &&
     parity_mode == PAR_ZERO) |-> unit_output_value_reg[CHANNEL] == inv)
    else $error("zero parity bit wrong");

  a_start_enables: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (wr_stb && addr == START_OFS && wdata[CHANNEL])
      |=> channel_enabled_reg)
    else $error("start trigger did not enable");

  a_stop_halts: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (wr_stb && addr == STOP_OFS && wdata[CHANNEL])
      |=> !channel_enabled_reg ##1 state_reg == ST_IDLE)
    else $error("stop trigger did not halt");

  a_oe_follow: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (wr_stb && addr == ENABLE_OFS)
      |=> ##1 txd_oe_reg == $past(wdata[CHANNEL], 2))
    else $error("output enable not applied");

  a_value_write: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (wr_stb && addr == VALUE_OFS && state_reg == ST_IDLE && !load)
      |=> ##1 txd_reg == $past(wdata[CHANNEL], 2))
    else $error("line value write not driven");

  a_irq_source: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (tx_irq_reg && !channel_mode_reg[IRQ_SRC_BIT] &&
     !$past(wr_hit(MODE_OFS))) |-> $past(state_reg) == ST_STOP)
    else $error("transfer end interrupt out of place");

  a_tick_source: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    bit_tick |-> $past(op_tick) && $past(state_reg) != ST_IDLE)
    else $error("transfer tick without operation tick");

  a_nine_bit: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    !NINE_BIT_OK |-> data_len != BITS_9)
    else $error("nine bit length on incapable channel");

  a_load_starts: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    load |=> state_reg == ST_START && index_reg == 4'h0)
    else $error("load did not open a frame");

  a_load_empties: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (load && !wr_hit(DATA_OFS)) |=> !pending_reg)
    else $error("buffer still full after load");

endmodule : uart_tx_channel

// ===== dv/uart_rx_model.sv
// far-side receiver: samples the serial line in mid-bit, records raw levels
// assumes the bench supplies idle level, bit period in clocks and bit count
`timescale 1ns/100ps
module uart_rx_model (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        txd,
  input  wire logic        txd_oe,
  input  wire logic        idle_lvl,
  input  wire logic [31:0] period,
  input  wire logic [31:0] nbits,
  output logic      [15:0] bits,
  output logic             done
);
  logic prev_lvl;

  initial begin
    done     = 1'b0;
    bits     = 16'h0000;
    prev_lvl = 1'b1;
    forever begin
      @(posedge sys_clk);
      // only a driven move off the idle level opens a frame, so a level
      // preset by software is not taken for a start bit
      if (rst_b && txd_oe && prev_lvl === idle_lvl && txd !== idle_lvl) begin
        repeat (period / 2) @(posedge sys_clk);
        for (int i = 0; i < nbits; i++) begin
          bits[i] = txd;
          if (i < nbits - 1) repeat (period) @(posedge sys_clk);
        end
        done <= 1'b1;
        @(posedge sys_clk);
        done <= 1'b0;
      end
      prev_lvl = txd;
    end
  end
endmodule : uart_rx_model

// ===== dv/tb.sv
// register-level bench of the transmit channel with a far-side receiver
// assumes channel 0, prescaler clock a ticking every cycle, b every second
`timescale 1ns/100ps
module tb;
  import uart_tx_pkg::*;
  logic              sys_clk  = 1'b0;
  logic              rst_b    = 1'b0;
  logic [ADDR_W-1:0] addr     = 6'h00;
  logic [DATA_W-1:0] wdata    = 16'h0000;
  logic              wr_stb   = 1'b0;
  logic              rd_stb   = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic              op_b     = 1'b0;
  logic              txd;
  logic              txd_oe;
  logic              tx_irq;
  logic              m_idle   = 1'b1;
  int unsigned       m_period = 6;
  int unsigned       m_nbits  = 10;
  logic [15:0]       m_bits;
  logic              m_done;
  int                failures = 0;
  int                comparisons = 0;
  int                irq_count = 0;
  logic [15:0]       v;
  logic [5:0]  ofs_t [9] = '{MODE_OFS, FORMAT_OFS, DATA_OFS, INVERT_OFS,
    VALUE_OFS, ENABLE_OFS, START_OFS, STATUS_OFS, 6'h3C};
  logic [15:0] rst_t [9] = '{MODE_RST, FORMAT_RST, DATA_RST, INVERT_RST,
    VALUE_RST, ENABLE_RST, 16'h0000, 16'h0000, 16'h0000};

  uart_tx_channel i_uart_tx_channel (
    .sys_clk(sys_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_reg(rdata),
    .prescaler_clock_a(1'b1), .prescaler_clock_b(op_b),
    .txd_reg(txd), .txd_oe_reg(txd_oe), .tx_irq_reg(tx_irq));
  uart_rx_model i_uart_rx_model (
    .sys_clk(sys_clk), .rst_b(rst_b), .txd(txd), .txd_oe(txd_oe),
    .idle_lvl(m_idle), .period(m_period), .nbits(m_nbits),
    .bits(m_bits), .done(m_done));

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    op_b <= ~op_b;
    if (tx_irq === 1'b1) irq_count <= irq_count + 1;
  end

  task print_verdict;
    if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task tick;
    @(posedge sys_clk);
    #1;
  endtask : tick

  task wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask : wr

  task rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  task automatic build(input logic [8:0] d, input logic [1:0] len, stp, par,
                       input bit lsb, output logic [15:0] b, output int n);
    int   nb;
    logic p;
    nb = (len == LEN_7) ? 7 : (len == LEN_9) ? 9 : 8;
    b = 16'h0000;
    n = 1;
    for (int i = 0; i < nb; i++) begin
      b[n] = lsb ? d[i] : d[nb-1-i];
      n++;
    end
    p = ^d;
    if (par == PAR_ZERO) p = 1'b0;
    else if (par != PAR_EVEN) p = ~p;
    if (par != PAR_NONE) begin
      b[n] = p;
      n++;
    end
    b[n] = 1'b1;
    n++;
    if (stp == STOP_TWO) begin
      b[n] = 1'b1;
      n++;
    end
  endtask : build

  task automatic frame(input logic [1:0] len, stp, par, input bit lsb, inv,
                       src, cb, input logic [8:0] d, input logic [6:0] div);
    logic [15:0] eb;
    logic [15:0] mask;
    int          n;
    int          i0;
    logic [15:0] fmt;
    build(d, len, stp, par, lsb, eb, n);
    fmt = {2'h2, 4'h0, par, lsb, 1'b0, stp, 2'h1, len};
    // model idle level moves first, so the preset is no start edge
    m_idle <= ~inv;
    wr(INVERT_OFS, {15'h0000, inv});
    wr(VALUE_OFS, {15'h0787, ~inv});
    wr(MODE_OFS, {cb, 1'b0, 11'h004, 2'h1, src});
    wr(FORMAT_OFS, fmt);
    m_period = 2 * (div + 1) * (cb ? 2 : 1);
    m_nbits  = n;
    i0 = irq_count;
    wr(DATA_OFS, {div, d});
    tick;
    tick;
    chk("line before start", {15'h0000, ~inv}, {15'h0000, txd});
    tick;
    chk("start bit", {15'h0000, inv}, {15'h0000, txd});
    chk("early irq", {15'h0000, src}, 16'(irq_count - i0));
    rd(VALUE_OFS, v);
    chk("value during frame", {15'h0000, inv}, v & 16'h0001);
    for (int k = 0; k < m_period * 16 && m_done !== 1'b1; k++) tick;
    mask = 16'((32'h1 << n) - 1);
    chk("frame", (eb ^ {16{inv}}) & mask, m_bits & mask);
    repeat (m_period) tick;
    chk("irq per frame", 16'h0001, 16'(irq_count - i0));
  endtask : frame

  initial begin
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    tick;
    chk("reset line", 16'h0001, {14'h0000, txd_oe, txd});
    wr(6'h3C, 16'hFFFF);
    wr(STATUS_OFS, 16'h0007);
    for (int i = 0; i < 9; i++) begin
      rd(ofs_t[i], v);
      chk("reset value", rst_t[i], v);
    end
    wr(ENABLE_OFS, 16'h0001);
    tick;
    tick;
    chk("output enable", 16'h0001, {15'h0000, txd_oe});
    m_idle <= 1'b0;
    wr(VALUE_OFS, 16'h0F0E);
    tick;
    tick;
    chk("written level", 16'h0000, {15'h0000, txd});
    wr(START_OFS, 16'h0001);
    rd(STATUS_OFS, v);
    chk("enabled", 16'h0001, v & 16'h0001);
    frame(2'h3, 2'h1, PAR_NONE, 0, 0, 0, 0, 9'h0A5, 7'h02);
    frame(LEN_7, STOP_TWO, PAR_EVEN, 1, 0, 1, 0, 9'h035, 7'h02);
    frame(LEN_9, 2'h1, 2'h3, 1, 0, 0, 0, 9'h1C3, 7'h02);
    frame(2'h3, 2'h1, PAR_ZERO, 0, 1, 0, 0, 9'h00F, 7'h02);
    frame(2'h3, STOP_TWO, PAR_EVEN, 1, 0, 0, 1, 9'h05A, 7'h02);
    frame(LEN_7, 2'h1, PAR_NONE, 0, 0, 0, 0, 9'h041, 7'h7F);
    wr(DATA_OFS, {7'h10, 9'h025});
    repeat (40) tick;
    wr(STOP_OFS, 16'h0001);
    rd(STATUS_OFS, v);
    chk("stopped", 16'h0000, v & 16'h0003);
    v = {15'h0000, txd};
    repeat (80) tick;
    chk("line frozen", v, {15'h0000, txd});
    wr(ENABLE_OFS, 16'h0000);
    tick;
    tick;
    chk("output released", 16'h0000, {15'h0000, txd_oe});
    print_verdict;
  end

  // the slowest frame takes about 2300 cycles (9 bits of 256); the whole run far less than the 20000-cycle limit
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    print_verdict;
  end
endmodule : tb
